// >>> rtl/axis_pkg.sv
// Shared constants and carrier types for one motion axis.
// Assumes a 20 MHz core clock and a 160 MHz virtual timebase for periods.
package axis_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_NS = 50;
	localparam int TB_HZ_I = 160_000_000;
	localparam logic [27:0] TB_HZ = 28'h9896800;
	localparam logic [27:0] TICKS_PER_CLK = 28'(TB_HZ_I / CLK_HZ);
	localparam int DEV_CLR_NS = 10_000_000;
	localparam int DEV_CLR_CYCLES = (DEV_CLR_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [21:0] HZ_MIN = 22'h000001;
	localparam logic [21:0] HZ_START_MIN = 22'h00000a;
	localparam logic [21:0] HZ_MAX_LOW = 22'h0186a0;
	localparam logic [21:0] HZ_MAX_MED = 22'h0c3500;
	localparam logic [21:0] HZ_MAX_HIGH = 22'h32dcd5;
	localparam logic [23:0] RB_SAT = 24'hffffff;
	localparam logic [21:0] RAMP_STEP_HZ = 22'h0003e8;
	localparam int RAMP_CLKS = 200;
	localparam int PIN_HALT = 0;
	localparam int PIN_CW = 1;
	localparam int PIN_CCW = 2;
	localparam int PIN_SETTLED = 3;
	typedef enum logic [1:0] {PAT_PULSE = 2'b00, PAT_ALL = 2'b01, PAT_NONE = 2'b10} irq_pat_t;
	typedef enum logic [1:0] {DT_LOW = 2'b00, DT_MED = 2'b01, DT_HIGH = 2'b10,
		DT_ARITH = 2'b11} drive_type_t;
	typedef enum logic [1:0] {S_IDLE = 2'b00, S_RUN = 2'b01, S_SETTLE = 2'b10} state_t;
	typedef enum logic [1:0] {END_NORMAL = 2'b00, END_SLOW = 2'b01, END_FAST = 2'b10,
		END_LIMIT = 2'b11} end_kind_t;
	typedef struct packed {
		logic servo;
		logic limit_slow;
		irq_pat_t irq_pat;
		drive_type_t drive_type;
	} spec_t;
	typedef struct packed {
		logic start;
		logic dir_neg;
		logic [23:0] count;
		logic [21:0] start_hz;
		logic [21:0] high_hz;
	} drive_req_t;
	typedef struct packed {
		logic slow;
		logic fast;
		logic limit;
	} stop_flags_t;
endpackage

// >>> rtl/axis_pulse_ctrl.sv
// One axis of pulse generation: stops, servo handshake, counters, readback.
// Assumes command strobes are one-cycle pulses on core_clk; pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module axis_pulse_ctrl
	import axis_pkg::*;
#(
	parameter int CLEAR_CYCLES = DEV_CLR_CYCLES,
	parameter int RAMP_CYCLES = RAMP_CLKS,
	parameter logic [21:0] RAMP_STEP = RAMP_STEP_HZ
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic emergency_halt,
	input wire logic cw_travel_limit_input,
	input wire logic ccw_travel_limit_input,
	input wire logic deviation_settled_input,
	input wire logic spec_load,
	input wire spec_t spec_in,
	input wire drive_req_t drive_req,
	input wire logic slow_stop_cmd,
	input wire logic fast_stop_cmd,
	input wire logic deviation_clear_cmd,
	input wire logic position_load_command,
	input wire logic [23:0] position_load_value,
	input wire logic other_cmd_done,
	input wire logic speed_port_select,
	input wire logic count_port_select,
	input wire logic [23:0] count_compare,
	input wire logic [23:0] deviation_compare,
	input wire logic deviation_irq_above,
	input wire logic gp_out,
	output logic pulse_out,
	output logic dir_out,
	output logic busy,
	output logic drive_active,
	output stop_flags_t stop_flags,
	output logic deviation_clear_output,
	output logic gp_in,
	output logic command_done_interrupt,
	output logic pulse_count_match_interrupt,
	output logic deviation_count_interrupt,
	output logic [23:0] position,
	output logic [23:0] drive_readback_port
);
	localparam int CW = $clog2(CLEAR_CYCLES + 1);
	localparam int RW = $clog2(RAMP_CYCLES + 1);
	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		state_t st;
		spec_t spec;
		logic div_on;
		logic [4:0] div_cnt;
		logic [22:0] rem;
		logic [27:0] quo;
		logic [27:0] period;
		logic [27:0] phase;
		logic [21:0] cur_hz;
		logic [21:0] start_hz;
		logic [21:0] high_hz;
		logic [RW-1:0] ramp_cnt;
		logic [23:0] remain;
		logic endless;
		logic dir_neg;
		logic slowing;
		end_kind_t kind;
		logic pulse;
		logic [23:0] pos;
		logic [23:0] pcount;
		logic [23:0] dev;
		logic [CW-1:0] clr_cnt;
		logic clr_n;
		logic gp_in;
		stop_flags_t flags;
		logic done_irq;
		logic cnt_irq;
		logic dev_irq;
		logic sel_speed;
		logic [23:0] readback;
		logic busy;
	} axis_state_t;

	axis_state_t s;
	axis_state_t next_s;
	logic [28:0] ph;
	logic [22:0] r;
	logic [21:0] goal;
	logic halt;
	logic lim_hit;
	logic fin;
	end_kind_t ek;

	// Speed clamp per drive type; start speeds keep a higher floor
	function automatic logic [21:0] clamp_hz(input logic [21:0] v, input logic is_start,
		input drive_type_t t);
		logic [21:0] lo;
		logic [21:0] hi;
		lo = is_start ? HZ_START_MIN : HZ_MIN;
		unique case (t)
			DT_LOW: hi = HZ_MAX_LOW;
			DT_MED: hi = HZ_MAX_MED;
			DT_HIGH, DT_ARITH: hi = HZ_MAX_HIGH;
		endcase
		if (v < lo) begin
			return lo;
		end
		if (v > hi) begin
			return hi;
		end
		return v;
	endfunction

	always_comb begin
		next_s = s;
		ph = '0;
		r = '0;
		goal = '0;
		fin = 1'b0;
		ek = END_NORMAL;
		next_s.s1 = {deviation_settled_input, ccw_travel_limit_input, cw_travel_limit_input,
			emergency_halt};
		next_s.s2 = s.s1;
		halt = s.s2[PIN_HALT];
		lim_hit = s.dir_neg ? s.s2[PIN_CCW] : s.s2[PIN_CW];
		next_s.pulse = 1'b0;
		next_s.done_irq = 1'b0;
		next_s.cnt_irq = 1'b0;
		if (spec_load && s.st == S_IDLE) begin
			next_s.spec = spec_in;
		end
		if (speed_port_select) begin
			next_s.sel_speed = 1'b1;
		end else if (count_port_select) begin
			next_s.sel_speed = 1'b0;
		end
		if (position_load_command) begin
			next_s.pos = position_load_value;
		end
		// Background divider: 28 restoring steps give the integer period
		if (s.div_on) begin
			r = {s.rem[21:0], TB_HZ[s.div_cnt]};
			if (r >= {1'b0, s.cur_hz}) begin
				next_s.rem = r - {1'b0, s.cur_hz};
				next_s.quo = {s.quo[26:0], 1'b1};
			end else begin
				next_s.rem = r;
				next_s.quo = {s.quo[26:0], 1'b0};
			end
			next_s.div_cnt = s.div_cnt - 5'd1;
			if (s.div_cnt == 5'd0) begin
				next_s.div_on = 1'b0;
				next_s.period = next_s.quo;
			end
		end
		unique case (s.st)
			S_IDLE: begin
				if (drive_req.start) begin
					next_s.st = S_RUN;
					next_s.flags = '0;
					next_s.dir_neg = drive_req.dir_neg;
					next_s.remain = drive_req.count;
					next_s.endless = (drive_req.count == 24'h000000);
					next_s.start_hz = clamp_hz(drive_req.start_hz, 1'b1, s.spec.drive_type);
					next_s.high_hz = clamp_hz(drive_req.high_hz, 1'b0, s.spec.drive_type);
					next_s.cur_hz = next_s.start_hz;
					next_s.period = '0;
					next_s.phase = '0;
					next_s.pcount = '0;
					next_s.slowing = 1'b0;
					next_s.ramp_cnt = RW'(RAMP_CYCLES);
					next_s.div_on = 1'b1;
					next_s.div_cnt = 5'd27;
					next_s.rem = '0;
					next_s.quo = '0;
				end
			end
			S_RUN: begin
				if (halt || fast_stop_cmd) begin
					fin = 1'b1;
					ek = END_FAST;
				end else if (lim_hit && !s.spec.limit_slow) begin
					fin = 1'b1;
					ek = END_LIMIT;
				end else begin
					if (slow_stop_cmd || (lim_hit && s.spec.limit_slow)) begin
						next_s.slowing = 1'b1;
						if (lim_hit) begin
							next_s.kind = END_LIMIT;
						end else if (!s.slowing) begin
							next_s.kind = END_SLOW;
						end
					end
					// Pulses are counted in 160 MHz ticks, eight per core cycle
					ph = {1'b0, s.phase} + {1'b0, TICKS_PER_CLK};
					if (s.period != 28'h0000000 && ph >= {1'b0, s.period}) begin
						next_s.phase = 28'(ph - {1'b0, s.period});
						next_s.pulse = 1'b1;
						next_s.pos = s.dir_neg ? s.pos - 24'h000001 : s.pos + 24'h000001;
						next_s.dev = s.dir_neg ? s.dev - 24'h000001 : s.dev + 24'h000001;
						next_s.pcount = s.pcount + 24'h000001;
						next_s.cnt_irq = (next_s.pcount == count_compare);
						next_s.remain = s.remain - 24'h000001;
						if (!s.endless && s.remain == 24'h000001) begin
							fin = 1'b1;
							ek = END_NORMAL;
						end
					end else begin
						next_s.phase = ph[27:0];
					end
					// Ramp toward the goal; a decelerating stop ends at start speed
					goal = next_s.slowing ? s.start_hz : s.high_hz;
					if (s.ramp_cnt != '0) begin
						next_s.ramp_cnt = s.ramp_cnt - RW'(1);
					end else if (!s.div_on) begin
						next_s.ramp_cnt = RW'(RAMP_CYCLES);
						if (s.cur_hz < goal) begin
							next_s.cur_hz = (goal - s.cur_hz > RAMP_STEP) ? s.cur_hz + RAMP_STEP : goal;
						end else if (s.cur_hz > goal) begin
							next_s.cur_hz = (s.cur_hz - goal > RAMP_STEP) ? s.cur_hz - RAMP_STEP : goal;
						end else if (s.slowing && !fin) begin
							fin = 1'b1;
							ek = s.kind;
						end
						if (next_s.cur_hz != s.cur_hz) begin
							next_s.div_on = 1'b1;
							next_s.div_cnt = 5'd27;
							next_s.rem = '0;
							next_s.quo = '0;
						end
					end
				end
				if (fin) begin
					next_s.kind = ek;
					next_s.div_on = 1'b0;
					if (s.spec.servo && ek != END_FAST && !(ek == END_LIMIT && !s.spec.limit_slow)) begin
						next_s.st = S_SETTLE;
					end else begin
						next_s.st = S_IDLE;
					end
				end
			end
			S_SETTLE: begin
				if (halt || fast_stop_cmd) begin
					next_s.kind = END_FAST;
					fin = 1'b1;
					next_s.st = S_IDLE;
				end else if (!s.s2[PIN_SETTLED]) begin
					next_s.st = S_IDLE;
				end
			end
			default: next_s.st = S_IDLE;
		endcase
		// Completion: flags, done request and servo clear on abrupt stops
		if (s.st != S_IDLE && next_s.st == S_IDLE) begin
			unique case (next_s.kind)
				END_SLOW: next_s.flags.slow = 1'b1;
				END_FAST: next_s.flags.fast = 1'b1;
				END_LIMIT: next_s.flags.limit = 1'b1;
				END_NORMAL: next_s.flags = s.flags;
			endcase
			next_s.done_irq = (s.spec.irq_pat == PAT_PULSE || s.spec.irq_pat == PAT_ALL);
			if (s.spec.servo && (next_s.kind == END_FAST ||
				(next_s.kind == END_LIMIT && !s.spec.limit_slow))) begin
				next_s.clr_cnt = CW'(CLEAR_CYCLES);
				next_s.dev = '0;
			end
		end
		// Counter and special commands never reach here; only ordinary non-pulse ones do
		if (other_cmd_done && s.spec.irq_pat == PAT_ALL) begin
			next_s.done_irq = 1'b1;
		end
		if (deviation_clear_cmd && s.spec.servo) begin
			next_s.clr_cnt = CW'(CLEAR_CYCLES);
			next_s.dev = '0;
		end else if (s.clr_cnt != '0 && next_s.clr_cnt == s.clr_cnt) begin
			next_s.clr_cnt = s.clr_cnt - CW'(1);
		end
		next_s.busy = (next_s.st != S_IDLE);
		// Stepping mode hands both servo pins to general purpose use
		next_s.clr_n = s.spec.servo ? (next_s.clr_cnt == '0) : gp_out;
		next_s.gp_in = s.spec.servo ? 1'b0 : s.s2[PIN_SETTLED];
		next_s.dev_irq = deviation_irq_above ? ($signed(s.dev) > $signed(deviation_compare))
			: ($signed(s.dev) < $signed(deviation_compare));
		// Periods past three bytes saturate, so very slow speeds read full scale (ffffff)
		if (s.sel_speed) begin
			next_s.readback = (s.period[27:24] != 4'h0) ? RB_SAT : s.period[23:0];
		end else begin
			next_s.readback = s.pcount;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.spec <= '{servo: 1'b0, limit_slow: 1'b0, irq_pat: PAT_PULSE, drive_type: DT_LOW};
			s.clr_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign pulse_out = s.pulse;
	assign dir_out = s.dir_neg;
	assign busy = s.busy;
	assign drive_active = s.busy;
	assign stop_flags = s.flags;
	assign deviation_clear_output = s.clr_n;
	assign gp_in = s.gp_in;
	assign command_done_interrupt = s.done_irq;
	assign pulse_count_match_interrupt = s.cnt_irq;
	assign deviation_count_interrupt = s.dev_irq;
	assign position = s.pos;
	assign drive_readback_port = s.readback;
endmodule
`default_nettype wire

// >>> verif/axis_pulse_ctrl_sva.sv
// Concurrent checks on the axis pulse controller ports.
// Assumes one core_clk domain and asynchronous active-low resetn.
`timescale 1ns/1ps
`default_nettype none
module axis_pulse_ctrl_sva
	import axis_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic emergency_halt,
	input wire logic cw_travel_limit_input,
	input wire logic fast_stop_cmd,
	input wire logic spec_load,
	input wire spec_t spec_in,
	input wire logic pulse_out,
	input wire logic dir_out,
	input wire logic busy,
	input wire stop_flags_t stop_flags,
	input wire logic command_done_interrupt,
	input wire logic pulse_count_match_interrupt
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// Slow-type limit stops decelerate first, so the short bound holds for fast-type only
	logic lim_slow;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			lim_slow <= 1'b0;
		end else if (spec_load && !busy) begin
			lim_slow <= spec_in.limit_slow;
		end
	end
	sequence s_fast_req;
		busy && fast_stop_cmd;
	endsequence
	sequence s_fast_end;
		!busy && stop_flags.fast;
	endsequence
	// Halt needs two synchroniser edges before it acts
	sequence s_halt_held;
		emergency_halt [*3];
	endsequence
	a_fast_stop_ends: assert property (s_fast_req |=> s_fast_end)
		else $error("fast stop did not end the drive");
	a_halt_stops_axis: assert property (s_halt_held |-> ##[0:1] !busy)
		else $error("halt did not stop the axis");
	a_cw_limit_stop: assert property ((!lim_slow && busy && !dir_out
		&& cw_travel_limit_input) [*3] |=> !busy)
		else $error("cw limit did not stop a positive move");
	a_pulse_single: assert property (pulse_out |=> !pulse_out)
		else $error("pulse wider than one cycle");
	a_idle_no_pulse: assert property (!busy && $past(!busy) |-> !pulse_out)
		else $error("pulse while idle");
	a_dir_steady: assert property (busy && $past(busy) |-> $stable(dir_out))
		else $error("direction changed in a drive");
	a_flags_cleared: assert property ($rose(busy) |-> ##[0:1] stop_flags == 3'h0)
		else $error("stop flags kept at drive start");
	a_done_single: assert property (command_done_interrupt |=> !command_done_interrupt)
		else $error("done request too long");
	a_match_single: assert property (pulse_count_match_interrupt
		|=> !pulse_count_match_interrupt)
		else $error("count match request too long");
endmodule
bind axis_pulse_ctrl axis_pulse_ctrl_sva chk (.core_clk(core_clk), .resetn(resetn),
	.emergency_halt(emergency_halt), .cw_travel_limit_input(cw_travel_limit_input),
	.fast_stop_cmd(fast_stop_cmd), .spec_load(spec_load), .spec_in(spec_in),
	.pulse_out(pulse_out), .dir_out(dir_out), .busy(busy),
	.stop_flags(stop_flags), .command_done_interrupt(command_done_interrupt),
	.pulse_count_match_interrupt(pulse_count_match_interrupt));
`default_nettype wire

// >>> verif/motor_driver_model.sv
// Behavioural servo or stepping driver amplifier for one axis.
// Assumes pulse_out is a one-cycle strobe on core_clk.
`timescale 1ns/1ps
`default_nettype none
module motor_driver_model (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic pulse_out,
	input wire logic dir_out,
	input wire logic deviation_clear_output,
	input wire logic [7:0] settle_delay,
	output logic deviation_settled_input,
	output int steps
);
	logic [7:0] lag;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			lag <= 8'h00;
			steps <= 0;
		end else begin
			if (pulse_out)
				steps <= dir_out ? steps - 1 : steps + 1;
			if (!deviation_clear_output)
				lag <= 8'h00;
			else if (pulse_out)
				lag <= settle_delay;
			else if (lag != 8'h00)
				lag <= lag - 8'h01;
		end
	end
	// Settling is slow on purpose so a design that ends early is caught
	assign deviation_settled_input = (lag != 8'h00);
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for one axis pulse controller.
// Assumes the driver model stands at the pulse and servo pins.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import axis_pkg::*;
	localparam int CLR = 20;
	logic core_clk, resetn, emergency_halt, cw, ccw, settled, spec_load;
	logic slow_stop_cmd, fast_stop_cmd, dev_clr_cmd, pos_load, spd_sel, cnt_sel, gp_out;
	logic pulse_out, dir_out, busy, drive_active, clr_out, done_irq, match_irq;
	logic [23:0] pos_val, count_compare, position, readback;
	logic [7:0] settle_delay;
	logic oth_done, dev_above, gp_in, dev_irq;
	logic [23:0] dev_cmp;
	spec_t spec_in;
	drive_req_t drive_req;
	stop_flags_t stop_flags;
	int errors, comparisons, cycles, done_cnt, match_cnt, steps, n;
	axis_pulse_ctrl #(.CLEAR_CYCLES(CLR), .RAMP_CYCLES(2), .RAMP_STEP(22'h0003e8)) DUT (
		.core_clk(core_clk), .resetn(resetn), .emergency_halt(emergency_halt),
		.cw_travel_limit_input(cw), .ccw_travel_limit_input(ccw),
		.deviation_settled_input(settled), .spec_load(spec_load), .spec_in(spec_in),
		.drive_req(drive_req), .slow_stop_cmd(slow_stop_cmd), .fast_stop_cmd(fast_stop_cmd),
		.deviation_clear_cmd(dev_clr_cmd), .position_load_command(pos_load),
		.position_load_value(pos_val), .other_cmd_done(oth_done), .speed_port_select(spd_sel),
		.count_port_select(cnt_sel), .count_compare(count_compare),
		.deviation_compare(dev_cmp), .deviation_irq_above(dev_above), .gp_out(gp_out),
		.pulse_out(pulse_out), .dir_out(dir_out), .busy(busy), .drive_active(drive_active),
		.stop_flags(stop_flags), .deviation_clear_output(clr_out), .gp_in(gp_in),
		.command_done_interrupt(done_irq), .pulse_count_match_interrupt(match_irq),
		.deviation_count_interrupt(dev_irq), .position(position), .drive_readback_port(readback));
	motor_driver_model drv (.core_clk(core_clk), .resetn(resetn), .pulse_out(pulse_out),
		.dir_out(dir_out), .deviation_clear_output(clr_out), .settle_delay(settle_delay),
		.deviation_settled_input(settled), .steps(steps));
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (done_irq === 1'b1) done_cnt++;
		if (match_irq === 1'b1) match_cnt++;
		if (cycles == 40000) begin
			errors++;
			complete_run;
		end
	end
	task automatic tick(int k = 1);
		repeat (k) @(posedge core_clk);
		#5;
	endtask
	task automatic check(logic [23:0] seen, logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic go(logic neg, logic [23:0] cnt, logic [21:0] lo, logic [21:0] hi);
		drive_req = '{1'b1, neg, cnt, lo, hi};
		tick;
		drive_req.start = 1'b0;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick;
		s = 1'b0;
	endtask
	task automatic wait_idle;
		n = 0;
		while (busy !== 1'b0 && n < 8000) begin
			tick;
			n++;
		end
		check(24'(busy), 24'h0);
	endtask
	task automatic clear_width;
		n = 0;
		while (clr_out === 1'b0 && n < 1000) begin
			tick;
			n++;
		end
	endtask
	task automatic t_basic;
		check(position, 24'h0);
		check(24'(stop_flags), 24'h0);
		check(24'(dev_irq), 24'h0);
		gp_out = 1'b0;
		tick(2);
		check(24'(clr_out), 24'h0);
		gp_out = 1'b1;
		pos_val = 24'hfffffd;
		pulse(pos_load);
		tick;
		check(position, 24'hfffffd);
		count_compare = 24'h000003;
		go(1'b0, 24'h000005, 22'h0f4240, 22'h0f4240);
		wait_idle;
		tick(2);
		check(position, 24'h000002);
		check(24'(steps), 24'h5);
		check(readback, 24'h000005);
		check(24'(done_cnt), 24'h1);
		check(24'(match_cnt), 24'h1);
		tick(3);
		check(24'(gp_in), 24'h1);
		tick(5);
		check(24'(gp_in), 24'h0);
		check(24'(dev_irq), 24'h1);
		pulse(oth_done);
		dev_above = 1'b0;
		dev_cmp = 24'h000004;
		tick(2);
		check(24'(dev_irq), 24'h0);
		check(24'(done_cnt), 24'h1);
		$display("index drive test done");
	endtask
	task automatic t_stops;
		spec_in = '{1'b0, 1'b0, PAT_ALL, DT_LOW};
		pulse(spec_load);
		pulse(pos_load);
		pulse(oth_done);
		tick;
		check(24'(done_cnt), 24'h2);
		go(1'b0, 24'h000000, 22'h2dc6c0, 22'h2dc6c0);
		tick(80);
		pulse(spd_sel);
		tick(3);
		check(readback, 24'h000640);
		pulse(cnt_sel);
		pulse(fast_stop_cmd);
		check(24'(busy), 24'h0);
		check(24'(stop_flags), 24'h2);
		check(24'(clr_out), 24'h1);
		check(24'(done_irq), 24'h1);
		tick;
		check(24'(done_cnt), 24'h3);
		go(1'b0, 24'h000000, 22'h015f90, 22'h0186a0);
		tick(60);
		pulse(slow_stop_cmd);
		wait_idle;
		check(24'(stop_flags), 24'h4);
		go(1'b0, 24'h000000, 22'h0f4240, 22'h0f4240);
		ccw = 1'b1;
		tick(8);
		check(24'(busy), 24'h1);
		ccw = 1'b0;
		cw = 1'b1;
		tick(6);
		check(24'(busy), 24'h0);
		check(24'(stop_flags), 24'h1);
		cw = 1'b0;
		go(1'b1, 24'h000000, 22'h0f4240, 22'h0f4240);
		emergency_halt = 1'b1;
		tick(4);
		check(24'(busy), 24'h0);
		check(24'(stop_flags), 24'h2);
		emergency_halt = 1'b0;
		tick(3);
		$display("stop test done");
	endtask
	task automatic t_servo;
		spec_in = '{1'b1, 1'b0, PAT_NONE, DT_HIGH};
		pulse(spec_load);
		pulse(dev_clr_cmd);
		clear_width;
		check(24'(n), 24'(CLR));
		tick(3);
		settle_delay = 8'h28;
		go(1'b0, 24'h000002, 22'h0f4240, 22'h0f4240);
		n = 0;
		while (steps < 7 && n < 500) begin
			tick;
			n++;
		end
		tick(5);
		check(24'(busy), 24'h1);
		check(24'(drive_active), 24'h1);
		check(24'(gp_in), 24'h0);
		wait_idle;
		check(24'(done_cnt), 24'h6);
		go(1'b0, 24'h000000, 22'h0f4240, 22'h0f4240);
		tick(40);
		pulse(fast_stop_cmd);
		check(24'(clr_out), 24'h0);
		clear_width;
		check(24'(n), 24'(CLR));
		check(24'(stop_flags), 24'h2);
		$display("servo test done");
	endtask
	task automatic complete_run;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		{resetn, emergency_halt, cw, ccw, spec_load, slow_stop_cmd, fast_stop_cmd} = '0;
		{dev_clr_cmd, pos_load, spd_sel, cnt_sel} = '0;
		gp_out = 1'b1;
		oth_done = 1'b0;
		dev_above = 1'b1;
		dev_cmp = 24'h000000;
		pos_val = 24'h0;
		count_compare = 24'hffffff;
		settle_delay = 8'h04;
		spec_in = '{1'b0, 1'b0, PAT_PULSE, DT_LOW};
		drive_req = '0;
		tick(4);
		resetn = 1'b1;
		tick(3);
		t_basic;
		t_stops;
		t_servo;
		complete_run;
	end
endmodule
`default_nettype wire
